// *** rtl/asp_pkg.sv ***
// Constants shared by the security password and seek command block
package asp_pkg;
  // Command codes
  localparam logic [7:0]  CMD_SET_PW    = 8'hF1;
  localparam logic [7:0]  CMD_UNLOCK    = 8'hF2;
  localparam logic [3:0]  CMD_SEEK_HI   = 4'h7;
  // Data sector layout, word indices and control word bits
  localparam logic [7:0]  WORD_CTRL     = 8'h00;
  localparam logic [7:0]  WORD_PW_FIRST = 8'h01;
  localparam logic [7:0]  WORD_LAST     = 8'hFF;
  localparam int          PW_WORDS      = 16;
  localparam int          PW_BITS       = 256;
  localparam int          ID_BIT        = 0;
  localparam int          LEVEL_BIT     = 8;
  localparam int          DH_LBA_BIT    = 6;
  // Unlock attempt counter load value
  localparam logic [2:0]  UNLOCK_TRIES  = 3'h5;
  localparam logic [2:0]  TRIES_NONE    = 3'h0;
  // APB register byte offsets
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h00;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h04;
  localparam logic [7:0]  REG_CTRL      = 8'h08;
  localparam logic [7:0]  REG_STATE     = 8'h0C;
  localparam logic [7:0]  REG_MAX_LBA   = 8'h10;
  localparam logic [7:0]  REG_GEOM      = 8'h14;
  // Interrupt status bits
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_ABORT     = 1;
  localparam int          IRQ_MISMATCH  = 2;
  localparam int          IRQ_W         = 3;
  localparam int          CTRL_FREEZE   = 0;
  // Reset values of the address limits
  localparam logic [27:0] MAX_LBA_RST   = 28'h0100000;
  localparam logic [15:0] CYLS_RST      = 16'h0400;
  localparam logic [4:0]  HEADS_RST     = 5'h10;
  // Command sequencer states, Gray along idle, transfer, evaluate
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_EVAL = 2'b11
  } asp_state_type;
endpackage

// *** rtl/asp_pw_store.sv ***
// One stored 32-byte password with full-width compare
`timescale 1ns/100ps
module asp_pw_store
(
  // Clock and non-volatile clear
  input  wire logic                          i_core_clk,
  input  wire logic                          i_clear,
  // Load and compare
  input  wire logic                          i_load,
  input  wire logic [asp_pkg::PW_BITS-1:0]   i_pw,
  output logic                               o_match
);
  logic [asp_pkg::PW_BITS-1:0]  pw_ff;
  logic [asp_pkg::PW_WORDS-1:0] word_eq;

  // No async reset: stored passwords survive hardware reset
  genvar g;
  generate
    for (g = 0; g < asp_pkg::PW_WORDS; g++)
    begin : g_word
      always_ff @(posedge i_core_clk)
      begin
        if (i_clear)
          pw_ff[g*16 +: 16] <= 16'h0000;
        else if (i_load)
          pw_ff[g*16 +: 16] <= i_pw[g*16 +: 16];
      end
      assign word_eq[g] = (pw_ff[g*16 +: 16] == i_pw[g*16 +: 16]);
    end
  endgenerate

  assign o_match = &word_eq; // RQ18
endmodule

// *** rtl/asp_cmd.sv ***
// Security set-password, unlock and seek command interpreter with APB registers
// Overview of operation
// RQ1 - Set-password F1h takes one sector: bit0 user/master, bit8 level, words 1-16 password.
// RQ2 - User, high level: store user password, arm lock; user or master unlocks.
// RQ3 - User, maximum level: store user password, arm lock; only user unlocks.
// RQ4 - Master identifier: replace master password only; lock enable and level untouched.
// RQ5 - Unlock F2h transfers exactly one sector with control word and password.
// RQ6 - Unlock sector bit0 selects user or master compare; words 1-16 password.
// RQ7 - Master identifier at high level compares against stored master password.
// RQ8 - Master identifier at maximum level rejects unlock without any compare.
// RQ9 - User identifier compares against stored user password at any level.
// RQ10 - Unlock mismatch aborts the command and decrements the attempt counter.
// RQ11 - Counter loads five; decrements only on mismatches while locked.
// RQ12 - Counter at zero aborts every unlock until hardware reset.
// RQ13 - Unlock while already unlocked leaves the attempt counter unchanged.
// RQ14 - Frozen mode rejects set-password and unlock; only reset clears it.
// RQ15 - Seek 7Xh does nothing but range-check the address, error if out of range.
// RQ16 - Seek LBA: bits 27-24 drive/head, 23-16 cyl high, 15-8 cyl low, 7-0 sector.
// RQ17 - Successful unlock compare clears locked at once and completes without error.
// RQ18 - Compare covers all 32 bytes; passwords and level persist across resets.
`timescale 1ns/100ps
module asp_cmd
(
  // Clock, reset and non-volatile clear
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_nv_clear,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Task file command
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_cmd,
  input  wire logic [7:0]  i_drive_head,
  input  wire logic [7:0]  i_cyl_hi,
  input  wire logic [7:0]  i_cyl_lo,
  input  wire logic [7:0]  i_sect_num,
  // Data sector words
  input  wire logic        i_data_valid,
  input  wire logic [15:0] i_data,
  // Command status
  output logic             o_busy,
  output logic             o_data_req,
  output logic             o_cmd_done,
  output logic             o_cmd_abort,
  output logic             o_addr_err,
  output logic             o_irq
);
  asp_pkg::asp_state_type state_ff, nxt_state;
  logic [7:0]                  idx_ff;
  logic [15:0]                 ctl_ff;
  logic                        kind_unl_ff;
  logic [asp_pkg::PW_BITS-1:0] rx_pw_ff;
  logic                        locked_ff, arm_pend_ff, frozen_ff, wr_ctrl;
  logic                        lock_en_ff, level_ff;
  logic [2:0]                  cnt_ff, nxt_cnt;
  logic [asp_pkg::IRQ_W-1:0]   irq_stat_ff, irq_mask_ff, nxt_irq_stat, irq_ev;
  logic [27:0]                 max_lba_ff;
  logic [15:0]                 cyls_ff;
  logic [4:0]                  heads_ff;

  // Command decode and address range check
  wire         is_set    = (i_cmd == asp_pkg::CMD_SET_PW);
  wire         is_unl    = (i_cmd == asp_pkg::CMD_UNLOCK);
  wire         is_seek   = (i_cmd[7:4] == asp_pkg::CMD_SEEK_HI);
  wire         is_sec    = is_set | is_unl;
  wire         take      = i_cmd_valid & (state_ff == asp_pkg::ST_IDLE);
  wire [27:0]  lba       = {i_drive_head[3:0], i_cyl_hi, i_cyl_lo, i_sect_num}; // RQ16
  wire         lba_ok    = (lba < max_lba_ff);
  wire         chs_ok    = ({i_cyl_hi, i_cyl_lo} < cyls_ff) &
                           ({1'b0, i_drive_head[3:0]} < heads_ff);
  wire         addr_ok   = i_drive_head[asp_pkg::DH_LBA_BIT] ? lba_ok : chs_ok; // RQ15
  wire         early_abt = (is_sec & frozen_ff) | // RQ14
                           (is_unl & (cnt_ff == asp_pkg::TRIES_NONE)) | // RQ12
                           ~(is_sec | is_seek);
  wire         start_sec = take & is_sec & ~early_abt; // RQ5
  wire         seek_fin  = take & is_seek;
  wire         early_fin = take & ~is_seek & early_abt;

  // Sector evaluation
  wire         in_xfer   = (state_ff == asp_pkg::ST_XFER);
  wire         eval      = (state_ff == asp_pkg::ST_EVAL);
  wire         ctl_id    = ctl_ff[asp_pkg::ID_BIT]; // RQ1 RQ6
  wire         ctl_lvl   = ctl_ff[asp_pkg::LEVEL_BIT];
  wire         user_hit, master_hit;
  wire         lvl_rej   = ctl_id & level_ff; // RQ8
  wire         pw_hit    = ctl_id ? master_hit : user_hit; // RQ7 RQ9
  wire         unl_ok    = eval & kind_unl_ff & ~lvl_rej & pw_hit;
  wire         unl_fail  = eval & kind_unl_ff & ~unl_ok;
  wire         mismatch  = eval & kind_unl_ff & ~lvl_rej & ~pw_hit; // RQ10
  wire         set_user  = eval & ~kind_unl_ff & ~ctl_id; // RQ2 RQ3
  wire         set_mstr  = eval & ~kind_unl_ff & ctl_id; // RQ4
  wire         nxt_done  = seek_fin | early_fin | eval;
  wire         nxt_abort = early_fin | unl_fail;
  wire         nxt_aerr  = seek_fin & ~addr_ok; // RQ15

  asp_pw_store u_user_pw
  (
    .i_core_clk (i_core_clk),
    .i_clear    (i_nv_clear),
    .i_load     (set_user),
    .i_pw       (rx_pw_ff),
    .o_match    (user_hit)
  );

  asp_pw_store u_master_pw
  (
    .i_core_clk (i_core_clk),
    .i_clear    (i_nv_clear),
    .i_load     (set_mstr),
    .i_pw       (rx_pw_ff),
    .o_match    (master_hit)
  );

  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      asp_pkg::ST_IDLE: if (start_sec) nxt_state = asp_pkg::ST_XFER;
      asp_pkg::ST_XFER: if (i_data_valid && idx_ff == asp_pkg::WORD_LAST)
                          nxt_state = asp_pkg::ST_EVAL; // RQ5
      asp_pkg::ST_EVAL: nxt_state = asp_pkg::ST_IDLE;
      default:          nxt_state = asp_pkg::ST_IDLE;
    endcase
  end

  // Only mismatches on a locked device spend an attempt
  assign nxt_cnt = (mismatch && locked_ff && cnt_ff != asp_pkg::TRIES_NONE) ?
                   cnt_ff - 3'h1 : cnt_ff; // RQ11 RQ13

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff    <= asp_pkg::ST_IDLE;
      idx_ff      <= asp_pkg::WORD_CTRL;
      kind_unl_ff <= 1'b0;
      cnt_ff      <= asp_pkg::UNLOCK_TRIES; // RQ11
      frozen_ff   <= 1'b0; // RQ14
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff   <= start_sec ? asp_pkg::WORD_CTRL :
                  (in_xfer & i_data_valid) ? idx_ff + 8'h01 : idx_ff;
      if (start_sec)
        kind_unl_ff <= is_unl;
      cnt_ff   <= nxt_cnt;
      if (wr_ctrl && i_pwdata[asp_pkg::CTRL_FREEZE])
        frozen_ff <= 1'b1;
    end
  end

  // Control word and password capture; reserved words are dropped
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      ctl_ff <= 16'h0000;
    else if (in_xfer && i_data_valid && idx_ff == asp_pkg::WORD_CTRL)
      ctl_ff <= i_data;
  end

  genvar g;
  generate
    for (g = 0; g < asp_pkg::PW_WORDS; g++)
    begin : g_rx
      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
          rx_pw_ff[g*16 +: 16] <= 16'h0000;
        else if (in_xfer && i_data_valid && idx_ff == asp_pkg::WORD_PW_FIRST + 8'(g))
          rx_pw_ff[g*16 +: 16] <= i_data; // RQ1 RQ6
      end
    end
  endgenerate

  // Lock state: locked comes up asserted, settles from lock enable one edge later
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      locked_ff   <= 1'b1;
      arm_pend_ff <= 1'b1;
    end
    else
    begin
      arm_pend_ff <= 1'b0;
      if (arm_pend_ff)
        locked_ff <= lock_en_ff; // RQ2 RQ3
      else if (unl_ok)
        locked_ff <= 1'b0; // RQ17
    end
  end

  // Persistent settings: cleared only by the non-volatile clear
  always_ff @(posedge i_core_clk)
  begin
    if (i_nv_clear)
    begin
      lock_en_ff <= 1'b0;
      level_ff   <= 1'b0;
    end
    else if (set_user)
    begin
      lock_en_ff <= 1'b1; // RQ2 RQ3
      level_ff   <= ctl_lvl; // RQ18
    end
  end

  // Command status outputs
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_busy      <= 1'b0;
      o_data_req  <= 1'b0;
      o_cmd_done  <= 1'b0;
      o_cmd_abort <= 1'b0;
      o_addr_err  <= 1'b0;
    end
    else
    begin
      o_busy      <= (nxt_state != asp_pkg::ST_IDLE);
      o_data_req  <= (nxt_state == asp_pkg::ST_XFER);
      o_cmd_done  <= nxt_done;
      o_cmd_abort <= nxt_abort; // RQ10 RQ12 RQ14
      o_addr_err  <= nxt_aerr;
    end
  end

  // APB slave, zero wait states, error on unmapped offsets
  wire setup   = i_psel & ~i_penable;
  wire wr_acc  = i_psel & i_penable & i_pwrite & o_pready;
  wire hit_st  = (i_paddr == asp_pkg::REG_IRQ_STAT);
  wire hit_mk  = (i_paddr == asp_pkg::REG_IRQ_MASK);
  wire hit_ct  = (i_paddr == asp_pkg::REG_CTRL);
  wire hit_sa  = (i_paddr == asp_pkg::REG_STATE);
  wire hit_ml  = (i_paddr == asp_pkg::REG_MAX_LBA);
  wire hit_ge  = (i_paddr == asp_pkg::REG_GEOM);
  wire hit     = hit_st | hit_mk | hit_ct | hit_sa | hit_ml | hit_ge;
  assign wr_ctrl = wr_acc & hit_ct;
  wire [31:0] rd_mux =
    hit_st ? {29'h0, irq_stat_ff} :
    hit_mk ? {29'h0, irq_mask_ff} :
    hit_ct ? {31'h0, frozen_ff} :
    hit_sa ? {25'h0, cnt_ff, frozen_ff, level_ff, lock_en_ff, locked_ff} :
    hit_ml ? {4'h0, max_lba_ff} :
    hit_ge ? {11'h0, heads_ff, cyls_ff} : 32'h0;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_prdata  <= (setup & ~i_pwrite) ? rd_mux : 32'h0;
      o_pready  <= setup;
      o_pslverr <= setup & ~hit;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_mask_ff <= 3'h0;
      max_lba_ff  <= asp_pkg::MAX_LBA_RST;
      cyls_ff     <= asp_pkg::CYLS_RST;
      heads_ff    <= asp_pkg::HEADS_RST;
    end
    else
    begin
      if (wr_acc && hit_mk)
        irq_mask_ff <= i_pwdata[asp_pkg::IRQ_W-1:0];
      if (wr_acc && hit_ml)
        max_lba_ff <= i_pwdata[27:0];
      if (wr_acc && hit_ge)
      begin
        cyls_ff  <= i_pwdata[15:0];
        heads_ff <= i_pwdata[20:16];
      end
    end
  end

  // Interrupts: a new event beats a same-cycle write-one-to-clear
  assign irq_ev = {mismatch, nxt_abort, nxt_done};
  assign nxt_irq_stat = (irq_stat_ff &
                         ~((wr_acc && hit_st) ? i_pwdata[asp_pkg::IRQ_W-1:0] : 3'h0)) | irq_ev;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_stat_ff <= 3'h0;
      o_irq       <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      o_irq       <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_last_word;
    in_xfer && i_data_valid && idx_ff == asp_pkg::WORD_LAST;
  endsequence
  sequence s_finish;
    eval ##1 (o_cmd_done && !o_busy);
  endsequence

  chk_one_sector: assert property (s_last_word |=> s_finish) // RQ5
    else $error("sector end did not finish command");
  chk_user_arms: assert property (set_user |=> lock_en_ff && level_ff == $past(ctl_lvl)) // RQ2
    else $error("user set-password did not arm lock");
  chk_master_only: assert property (set_mstr |=> $stable(lock_en_ff) && $stable(level_ff)) // RQ4
    else $error("master set-password changed lock state");
  chk_max_rejects: assert property (eval && kind_unl_ff && ctl_id && level_ff
                                    |=> o_cmd_abort && locked_ff == $past(locked_ff)) // RQ8
    else $error("master unlock at maximum level not rejected");
  chk_miss_dec: assert property (mismatch && locked_ff && cnt_ff != asp_pkg::TRIES_NONE
                                 |=> o_cmd_abort && cnt_ff == $past(cnt_ff) - 3'h1) // RQ10
    else $error("mismatch did not abort and decrement");
  chk_unlocked_cnt: assert property (eval && kind_unl_ff && !locked_ff |=> $stable(cnt_ff)) // RQ13
    else $error("counter moved on unlocked device");
  chk_zero_aborts: assert property (take && is_unl && cnt_ff == asp_pkg::TRIES_NONE
                                    |=> o_cmd_abort && o_cmd_done && !o_data_req) // RQ12
    else $error("unlock accepted with no attempts left");
  chk_frozen_rej: assert property (take && is_sec && frozen_ff |=> o_cmd_abort && !o_busy) // RQ14
    else $error("security command accepted while frozen");
  chk_seek_range: assert property (seek_fin |=> o_cmd_done && o_addr_err == !$past(addr_ok)) // RQ15
    else $error("seek range result wrong");
  chk_unlock_ok: assert property (unl_ok |=> !locked_ff && o_cmd_done && !o_cmd_abort) // RQ17
    else $error("good unlock did not clear lock");
  chk_cnt_bound: assert property (cnt_ff <= asp_pkg::UNLOCK_TRIES) // RQ11
    else $error("attempt counter above load value");
endmodule

// *** sim/asp_host_model.sv ***
// Host controller model: issues task file commands and sends one data sector
`timescale 1ns/100ps
module asp_host_model
(
  // Clock and device status
  input  wire logic        i_core_clk,
  input  wire logic        i_data_req,
  input  wire logic        i_cmd_done,
  input  wire logic        i_cmd_abort,
  input  wire logic        i_addr_err,
  // Task file and sector data
  output logic             o_cmd_valid,
  output logic [7:0]       o_cmd,
  output logic [7:0]       o_drive_head,
  output logic [7:0]       o_cyl_hi,
  output logic [7:0]       o_cyl_lo,
  output logic [7:0]       o_sect_num,
  output logic             o_data_valid,
  output logic [15:0]      o_data
);
  initial
  begin
    o_cmd_valid = 1'h0;
    {o_cmd, o_drive_head, o_cyl_hi, o_cyl_lo, o_sect_num} = 40'h0;
    o_data_valid = 1'h0;
    o_data = 16'h0;
  end

  task automatic run(input logic [7:0] c, dh, ch, cl, sn, input logic [15:0] ctrl,
                     input logic [255:0] pw, output logic ab, output logic ae);
    int          n;
    logic [15:0] w;
    ab = 1'hx;
    ae = 1'hx;
    @(posedge i_core_clk);
    o_cmd_valid <= 1'h1;
    {o_cmd, o_drive_head, o_cyl_hi, o_cyl_lo, o_sect_num} <= {c, dh, ch, cl, sn};
    @(posedge i_core_clk);
    o_cmd_valid <= 1'h0;
    // Released task file shows the inverse so a stale value cannot pass
    {o_cmd, o_drive_head, o_cyl_hi, o_cyl_lo, o_sect_num} <= ~{c, dh, ch, cl, sn};
    @(negedge i_core_clk);
    // A refused command never opens a data phase, so no sector is sent
    if (i_cmd_done !== 1'h1 && i_data_req === 1'h1)
    begin
      for (n = 0; n < 256; n++)
      begin
        w = (n == 0) ? ctrl : (n <= 16) ? pw[(n-1)*16 +: 16] : ~16'(n);
        @(posedge i_core_clk);
        o_data_valid <= 1'h1;
        o_data <= w;
      end
      @(posedge i_core_clk);
      o_data_valid <= 1'h0;
      o_data <= ~w;
    end
    n = 0;
    while (i_cmd_done !== 1'h1 && n < 50)
    begin
      @(negedge i_core_clk);
      n++;
    end
    if (i_cmd_done === 1'h1)
    begin
      ab = i_cmd_abort;
      ae = i_addr_err;
    end
  endtask
endmodule

// *** sim/asp_cmd_tb_top.sv ***
// Self-checking bench for the security password and seek command block
`timescale 1ns/100ps
`define CMP(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module asp_cmd_tb_top;
  localparam logic [255:0] PW_U  = {8{32'h0123_4567}};
  localparam logic [255:0] PW_M  = {8{32'h89AB_CDEF}};
  // Differs from the user password in the last byte only
  localparam logic [255:0] PW_X  = PW_U ^ {8'h01, 248'h0};
  int                      miscompares = 0;
  int                      total_checks = 0;
  logic                    i_core_clk = 1'h0;
  logic                    i_rst = 1'h1;
  logic                    i_nv_clear = 1'h1;
  logic                    i_psel = 1'h0;
  logic                    i_penable = 1'h0;
  logic                    i_pwrite = 1'h0;
  logic [7:0]              i_paddr = 8'h0;
  logic [31:0]             i_pwdata = 32'h0;
  logic [31:0]             o_prdata;
  logic                    o_pready, o_pslverr, cmd_valid, data_valid, busy, data_req;
  logic                    done, abort, addr_err, o_irq;
  logic [7:0]              cmd, dh, ch, cl, sn;
  logic [15:0]             data;

  asp_cmd DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_nv_clear(i_nv_clear),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_drive_head(dh), .i_cyl_hi(ch), .i_cyl_lo(cl),
    .i_sect_num(sn), .i_data_valid(data_valid), .i_data(data), .o_busy(busy),
    .o_data_req(data_req), .o_cmd_done(done), .o_cmd_abort(abort), .o_addr_err(addr_err),
    .o_irq(o_irq));
  asp_host_model u_host (.i_core_clk(i_core_clk), .i_data_req(data_req), .i_cmd_done(done),
    .i_cmd_abort(abort), .i_addr_err(addr_err), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .o_drive_head(dh), .o_cyl_hi(ch), .o_cyl_lo(cl), .o_sect_num(sn),
    .o_data_valid(data_valid), .o_data(data));

  initial
  begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge i_core_clk);
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_core_clk);
    i_penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (o_pready !== 1'h1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    if (o_pready !== 1'h1)
      miscompares++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'h1, a, d, rd, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'h0, a, 32'h0, rd, e);
    `CMP(rd, exp)
  endtask

  task automatic sec(input logic [7:0] c, input logic [15:0] ctrl, input logic [255:0] pw,
                     input logic exp_ab);
    logic ab, ae;
    u_host.run(c, 8'hE0, 8'h00, 8'h00, 8'h00, ctrl, pw, ab, ae);
    `CMP(ab, exp_ab)
    `CMP({busy, data_req}, 2'h0)
  endtask

  task automatic seek(input logic [7:0] c, dh, ch, cl, sn, input logic exp_ae);
    logic ab, ae;
    u_host.run(c, dh, ch, cl, sn, 16'h0, 256'h0, ab, ae);
    `CMP(ae, exp_ae)
    `CMP(ab, 1'h0)
  endtask

  task automatic hw_reset;
    @(posedge i_core_clk);
    i_rst <= 1'h1;
    @(posedge i_core_clk);
    i_rst <= 1'h0;
    repeat (2) @(posedge i_core_clk);
  endtask

  task automatic test_high;
    rdchk(asp_pkg::REG_STATE, 32'h50);
    sec(asp_pkg::CMD_SET_PW, 16'h0101, PW_M, 1'h0);
    rdchk(asp_pkg::REG_STATE, 32'h50);
    sec(asp_pkg::CMD_SET_PW, 16'h0000, PW_U, 1'h0);
    rdchk(asp_pkg::REG_STATE, 32'h52);
    hw_reset;
    rdchk(asp_pkg::REG_STATE, 32'h53);
    sec(asp_pkg::CMD_UNLOCK, 16'h0000, PW_X, 1'h1);
    rdchk(asp_pkg::REG_STATE, 32'h43);
    sec(asp_pkg::CMD_UNLOCK, 16'h0001, PW_M, 1'h0);
    rdchk(asp_pkg::REG_STATE, 32'h42);
    sec(asp_pkg::CMD_UNLOCK, 16'h0000, PW_X, 1'h1);
    rdchk(asp_pkg::REG_STATE, 32'h42);
  endtask

  task automatic test_max;
    int i;
    sec(asp_pkg::CMD_SET_PW, 16'h0100, PW_U, 1'h0);
    rdchk(asp_pkg::REG_STATE, 32'h46);
    hw_reset;
    sec(asp_pkg::CMD_UNLOCK, 16'h0001, PW_M, 1'h1);
    rdchk(asp_pkg::REG_STATE, 32'h57);
    sec(asp_pkg::CMD_UNLOCK, 16'h0000, PW_U, 1'h0);
    rdchk(asp_pkg::REG_STATE, 32'h56);
    hw_reset;
    for (i = 0; i < 5; i++)
      sec(asp_pkg::CMD_UNLOCK, 16'h0000, PW_X, 1'h1);
    rdchk(asp_pkg::REG_STATE, 32'h07);
    sec(asp_pkg::CMD_UNLOCK, 16'h0000, PW_U, 1'h1);
    rdchk(asp_pkg::REG_STATE, 32'h07);
    hw_reset;
    rdchk(asp_pkg::REG_STATE, 32'h57);
  endtask

  task automatic test_freeze;
    wr(asp_pkg::REG_CTRL, 32'h1);
    rdchk(asp_pkg::REG_STATE, 32'h5F);
    sec(asp_pkg::CMD_UNLOCK, 16'h0000, PW_U, 1'h1);
    sec(asp_pkg::CMD_SET_PW, 16'h0000, PW_M, 1'h1);
    hw_reset;
    rdchk(asp_pkg::REG_STATE, 32'h57);
  endtask

  task automatic test_seek;
    int i;
    for (i = 0; i < 16; i++)
    begin
      seek(8'h70 | 8'(i), 8'hE0, 8'h0F, 8'hFF, 8'hFF, 1'h0);
      seek(8'h70 | 8'(i), 8'hE0, 8'h10, 8'h00, 8'h00, 1'h1);
    end
    seek(8'h70, 8'hE1, 8'h00, 8'h00, 8'h00, 1'h1);
    seek(8'h70, 8'hAF, 8'h03, 8'hFF, 8'h00, 1'h0);
    seek(8'h7F, 8'hAF, 8'h04, 8'h00, 8'h00, 1'h1);
  endtask

  task automatic test_irq;
    logic [31:0] rd;
    logic        e;
    rdchk(asp_pkg::REG_IRQ_MASK, 32'h0);
    wr(asp_pkg::REG_IRQ_STAT, 32'h7);
    sec(8'hEF, 16'h0, 256'h0, 1'h1);
    rdchk(asp_pkg::REG_IRQ_STAT, 32'h3);
    `CMP(o_irq, 1'h0)
    wr(asp_pkg::REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge i_core_clk);
    `CMP(o_irq, 1'h1)
    wr(asp_pkg::REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge i_core_clk);
    `CMP(o_irq, 1'h0)
    rdchk(asp_pkg::REG_IRQ_STAT, 32'h1);
    apb(1'h0, 8'h18, 32'h0, rd, e);
    `CMP({e, rd}, 33'h100000000)
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run needs about 4000 cycles
  initial
  begin
    #1000000;
    miscompares++;
    report_and_stop;
  end

  initial
  begin
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'h0;
    i_nv_clear <= 1'h0;
    repeat (2) @(posedge i_core_clk);
    test_high;
    test_max;
    test_freeze;
    test_seek;
    test_irq;
    report_and_stop;
  end
endmodule
